// >>> smpt_unit.sv
// 128-bit vector move, permute and sign-test datapath with its enable gating.
// Assumes an APB master on ref_clk_i; operands and memory image are staged
// in registers, one write of CTRL with the go bit executes one operation.
// Function
// - Broadcast one 32-bit memory element into all four lanes
// - Masked load keeps selected single or double elements from memory
// - Masked store writes only selected elements to memory
// - Variable permute picks elements by selectors from second operand
// - Immediate permute picks elements by immediate byte selectors
// - Zero flag set when AND of operands has all sign bits zero
// - Carry flag set when second AND NOT first has all sign bits zero
// - Double test uses 64-bit element sign bits
// - New 128-bit blend accepts only explicit mask, not implied form
// - Operations with 256-bit form also decode in 128-bit form
// - Legacy multimedia register operations have no new encoding
// - Scalar and vector-integer ops decode only as new 128-bit form
// - Fault on extended-vector ops unless OS enabled wide state
// - OS state flag implies save, restore, read and control register; only the read and the control write are built here
// - Control register write only at privileged level
// - Read with index zero returns control register in data pair
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module smpt_unit #(
	parameter logic HW_EXT_SUPPORT = 1'b1
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             zero_flag_o,
	output logic             carry_flag_o,
	output logic             undefined_opcode_fault_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [127:0]        opa_ff, nxt_opa;
	logic [127:0]        opb_ff, nxt_opb;
	logic [127:0]        res_ff, nxt_res;
	logic [127:0]        mem_ff, nxt_mem;
	logic [63:0]         xcr_ff, nxt_xcr;
	logic                osxs_ff, nxt_osxs;
	smpt_pkg::smpt_cmd_t cmd_ff, nxt_cmd;
	smpt_pkg::smpt_flags_t flg_ff, nxt_flg;
	logic [31:0]         rdata_ff, nxt_rdata;
	logic                slverr_ff, nxt_slverr;
	logic                rdv_ff, nxt_rdv;

	logic                wr_acc;
	logic                rd_acc;
	logic                go;
	logic [31:0]         wmask;
	logic                mapped;
	smpt_pkg::smpt_cmd_t go_cmd;
	logic                vec_en;
	logic                legal;
	logic [127:0]        exe_res;
	logic [127:0]        exe_mem;
	logic                exe_zf;
	logic                exe_cf;
	logic                wr_res;
	logic                wr_mem;
	logic                wr_xcr;
	logic                wr_flags;
	logic [31:0]         feat_word;

	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign rd_acc = psel_i & penable_i & ~pwrite_i;
	assign wmask  = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
	assign go     = wr_acc & (paddr_i == smpt_pkg::ADDR_CTRL)
		& pwdata_i[smpt_pkg::CTRL_GO_BIT];

	// Read data is registered, so a read waits one cycle for it to stand
	// at the pready edge; writes still complete in their first access cycle
	assign pready_o  = ~rd_acc | rdv_ff;
	assign prdata_o  = rdata_ff;
	assign pslverr_o = slverr_ff;

	assign zero_flag_o              = flg_ff.zf;
	assign carry_flag_o             = flg_ff.cf;
	assign undefined_opcode_fault_o = flg_ff.ud;

	always_comb
	begin
		go_cmd.op   = smpt_pkg::smpt_op_t'(pwdata_i[smpt_pkg::CTRL_OP_LSB +: 4]);
		go_cmd.enc  = smpt_pkg::smpt_enc_t'(pwdata_i[smpt_pkg::CTRL_ENC_LSB +: 2]);
		go_cmd.imm  = pwdata_i[smpt_pkg::CTRL_IMM_LSB +: 8];
		go_cmd.priv = pwdata_i[smpt_pkg::CTRL_PRIV_BIT];
	end

	// ----------------------------------------
	// Decode and enable gating
	// ----------------------------------------
	// State-save bit always reads one, though save and restore are not built
	// in here; only the control-register read and write are
	assign feat_word = (32'(osxs_ff) << smpt_pkg::FEAT_OSXS_BIT)
		| (32'(HW_EXT_SUPPORT) << smpt_pkg::FEAT_EXT_BIT)
		| (32'h1 << smpt_pkg::FEAT_STATE_SAVE_BIT);

	// Hardware support alone is not enough: the OS must enable both states
	assign vec_en = HW_EXT_SUPPORT
		& ((xcr_ff & smpt_pkg::XCR_VECMSK) == smpt_pkg::XCR_VECMSK);

	always_comb
	begin
		legal = 1'b0;
		case (go_cmd.op)
			smpt_pkg::OP_XGET:
				legal = osxs_ff;
			smpt_pkg::OP_XSET:
				legal = osxs_ff & go_cmd.priv;
			smpt_pkg::OP_MMXREF:
				legal = (go_cmd.enc == smpt_pkg::ENC_LEGACY);
			smpt_pkg::OP_BLENDV:
				legal = vec_en & (go_cmd.enc == smpt_pkg::ENC_NEW128);
			smpt_pkg::OP_BCAST, smpt_pkg::OP_MLOAD_S, smpt_pkg::OP_MLOAD_D,
			smpt_pkg::OP_MSTORE_S, smpt_pkg::OP_MSTORE_D, smpt_pkg::OP_PERMV_S,
			smpt_pkg::OP_PERMV_D, smpt_pkg::OP_PERMI_S, smpt_pkg::OP_PERMI_D,
			smpt_pkg::OP_TEST_S, smpt_pkg::OP_TEST_D:
				// New 128-bit form decodes for all of these; the 256-bit
				// form is outside this unit and also refused here
				legal = vec_en & (go_cmd.enc == smpt_pkg::ENC_NEW128);
			default:
				legal = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	always_comb
	begin
		logic [31:0]  a32 [4];
		logic [31:0]  b32 [4];
		logic [31:0]  m32 [4];
		logic [63:0]  a64 [2];
		logic [63:0]  b64 [2];
		logic [63:0]  m64 [2];
		logic [127:0] ld_s, st_s, pv_s, pi_s, bl_s;
		logic [127:0] ld_d, st_d, pv_d, pi_d;
		logic [127:0] t_and;
		logic [127:0] t_andn;
		for (int i = 0; i < 4; i++)
		begin
			a32[i] = opa_ff[32*i +: 32];
			b32[i] = opb_ff[32*i +: 32];
			m32[i] = mem_ff[32*i +: 32];
		end
		for (int i = 0; i < 2; i++)
		begin
			a64[i] = opa_ff[64*i +: 64];
			b64[i] = opb_ff[64*i +: 64];
			m64[i] = mem_ff[64*i +: 64];
		end
		// Every candidate result is formed at once; the op code only picks one.
		// Load and store mask bits are the sign bits of opa, store data comes from opb
		for (int i = 0; i < 4; i++)
		begin
			ld_s[32*i +: 32] = a32[i][31] ? m32[i] : 32'h0;
			st_s[32*i +: 32] = a32[i][31] ? b32[i] : m32[i];
			pv_s[32*i +: 32] = a32[b32[i][1:0]];
			pi_s[32*i +: 32] = a32[go_cmd.imm[2*i +: 2]];
			// Explicit mask in opb selects opa lanes over memory lanes
			bl_s[32*i +: 32] = b32[i][31] ? a32[i] : m32[i];
		end
		// Double selector sits in bit 1 of each 64-bit control
		for (int i = 0; i < 2; i++)
		begin
			ld_d[64*i +: 64] = a64[i][63] ? m64[i] : 64'h0;
			st_d[64*i +: 64] = a64[i][63] ? b64[i] : m64[i];
			pv_d[64*i +: 64] = a64[b64[i][1]];
			pi_d[64*i +: 64] = a64[go_cmd.imm[i]];
		end
		t_and   = opb_ff & opa_ff;
		t_andn  = opb_ff & ~opa_ff;
		exe_res = res_ff;
		exe_mem = mem_ff;
		exe_zf  = flg_ff.zf;
		exe_cf  = flg_ff.cf;
		case (go_cmd.op)
			smpt_pkg::OP_BCAST:    exe_res = {4{m32[0]}};
			smpt_pkg::OP_MLOAD_S:  exe_res = ld_s;
			smpt_pkg::OP_MLOAD_D:  exe_res = ld_d;
			smpt_pkg::OP_MSTORE_S: exe_mem = st_s;
			smpt_pkg::OP_MSTORE_D: exe_mem = st_d;
			smpt_pkg::OP_PERMV_S:  exe_res = pv_s;
			smpt_pkg::OP_PERMV_D:  exe_res = pv_d;
			smpt_pkg::OP_PERMI_S:  exe_res = pi_s;
			smpt_pkg::OP_PERMI_D:  exe_res = pi_d;
			smpt_pkg::OP_BLENDV:   exe_res = bl_s;
			smpt_pkg::OP_TEST_S:
			begin
				exe_zf = ~(t_and[31] | t_and[63] | t_and[95] | t_and[127]);
				exe_cf = ~(t_andn[31] | t_andn[63] | t_andn[95] | t_andn[127]);
			end
			smpt_pkg::OP_TEST_D:
			begin
				exe_zf = ~(t_and[63] | t_and[127]);
				exe_cf = ~(t_andn[63] | t_andn[127]);
			end
			smpt_pkg::OP_XGET:
				// Index zero in opa low word selects the control register
				exe_res = (a32[0] == 32'h0) ? {64'h0, xcr_ff} : 128'h0;
			default:
				exe_res = res_ff;
		endcase
		// Stores touch only memory and tests only the flags; the control
		// register write and the multimedia op leave the result alone
		wr_mem   = (go_cmd.op == smpt_pkg::OP_MSTORE_S)
			| (go_cmd.op == smpt_pkg::OP_MSTORE_D);
		wr_flags = (go_cmd.op == smpt_pkg::OP_TEST_S)
			| (go_cmd.op == smpt_pkg::OP_TEST_D);
		wr_res   = ~wr_mem & ~wr_flags & (go_cmd.op != smpt_pkg::OP_XSET)
			& (go_cmd.op != smpt_pkg::OP_MMXREF);
		// Bit 0 of the state register must stay set
		wr_xcr = (go_cmd.op == smpt_pkg::OP_XSET) & (a32[0] == 32'h0)
			& b32[0][0];
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_comb
	begin
		nxt_opa    = opa_ff;
		nxt_opb    = opb_ff;
		nxt_res    = res_ff;
		nxt_mem    = mem_ff;
		nxt_xcr    = xcr_ff;
		nxt_osxs   = osxs_ff;
		nxt_cmd    = cmd_ff;
		nxt_flg    = flg_ff;
		nxt_rdata  = 32'h0;
		nxt_slverr = 1'b0;
		nxt_rdv    = rd_acc & ~rdv_ff;
		mapped     = 1'b1;
		case (paddr_i[7:4])
			4'h0: mapped = (paddr_i[3:0] <= 4'hc) & (paddr_i[1:0] == 2'b00);
			4'h1: mapped = (paddr_i[3:0] == 4'h0);
			4'h2, 4'h3, 4'h4, 4'h5: mapped = (paddr_i[1:0] == 2'b00);
			default: mapped = 1'b0;
		endcase
		if (wr_acc & mapped)
		begin
			case (paddr_i[7:4])
				4'h2: nxt_opa[32*paddr_i[3:2] +: 32] =
					(opa_ff[32*paddr_i[3:2] +: 32] & ~wmask) | (pwdata_i & wmask);
				4'h3: nxt_opb[32*paddr_i[3:2] +: 32] =
					(opb_ff[32*paddr_i[3:2] +: 32] & ~wmask) | (pwdata_i & wmask);
				4'h5: nxt_mem[32*paddr_i[3:2] +: 32] =
					(mem_ff[32*paddr_i[3:2] +: 32] & ~wmask) | (pwdata_i & wmask);
				default:
				begin
					if (paddr_i == smpt_pkg::ADDR_FEAT)
						nxt_osxs = pwdata_i[smpt_pkg::FEAT_OSXS_BIT];
				end
			endcase
		end
		if (go)
		begin
			nxt_cmd = go_cmd;
			nxt_flg.ud = ~legal;
			if (legal)
			begin
				if (wr_res)
					nxt_res = exe_res;
				if (wr_mem)
					nxt_mem = exe_mem;
				if (wr_xcr)
					nxt_xcr = {opb_ff[127:96], b32_lo(opb_ff)};
				if (wr_flags)
				begin
					nxt_flg.zf = exe_zf;
					nxt_flg.cf = exe_cf;
				end
			end
		end
		if (rd_acc)
		begin
			nxt_slverr = ~mapped;
			case (paddr_i[7:4])
				4'h2: nxt_rdata = opa_ff[32*paddr_i[3:2] +: 32];
				4'h3: nxt_rdata = opb_ff[32*paddr_i[3:2] +: 32];
				4'h4: nxt_rdata = res_ff[32*paddr_i[3:2] +: 32];
				4'h5: nxt_rdata = mem_ff[32*paddr_i[3:2] +: 32];
				default:
				begin
					case (paddr_i)
						smpt_pkg::ADDR_CTRL: nxt_rdata = {6'h0, cmd_ff.enc,
							cmd_ff.imm, 4'h0, cmd_ff.op, 6'h0, cmd_ff.priv, 1'b0};
						smpt_pkg::ADDR_STATUS: nxt_rdata = {29'h0, flg_ff.ud,
							flg_ff.cf, flg_ff.zf};
						smpt_pkg::ADDR_FEAT:   nxt_rdata = feat_word;
						smpt_pkg::ADDR_XCR_LO: nxt_rdata = xcr_ff[31:0];
						smpt_pkg::ADDR_XCR_HI: nxt_rdata = xcr_ff[63:32];
						default:               nxt_rdata = 32'h0;
					endcase
				end
			endcase
		end
	end

	// Control register low word from opb low word, high word from opb word 3
	function automatic logic [31:0] b32_lo(input logic [127:0] v);
		b32_lo = v[31:0];
	endfunction : b32_lo

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			opa_ff    <= 128'h0;
			opb_ff    <= 128'h0;
			res_ff    <= 128'h0;
			mem_ff    <= 128'h0;
			xcr_ff    <= smpt_pkg::XCR_RESET;
			osxs_ff   <= 1'b0;
			cmd_ff    <= '0;
			flg_ff    <= '0;
			rdata_ff  <= 32'h0;
			slverr_ff <= 1'b0;
			rdv_ff    <= 1'b0;
		end
		else
		begin
			opa_ff    <= nxt_opa;
			opb_ff    <= nxt_opb;
			res_ff    <= nxt_res;
			mem_ff    <= nxt_mem;
			xcr_ff    <= nxt_xcr;
			osxs_ff   <= nxt_osxs;
			cmd_ff    <= nxt_cmd;
			flg_ff    <= nxt_flg;
			rdata_ff  <= nxt_rdata;
			slverr_ff <= nxt_slverr;
			rdv_ff    <= nxt_rdv;
		end
	end

endmodule : smpt_unit

// >>> smpt_pkg.sv
// Package for the 128-bit vector move, permute and sign-test unit.
// Assumes a single core clock; registers reached over APB with 32-bit data.
package smpt_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_FEAT    = 8'h08;
	localparam logic [7:0] ADDR_XCR_LO  = 8'h0c;
	localparam logic [7:0] ADDR_XCR_HI  = 8'h10;
	localparam logic [7:0] ADDR_OPA0    = 8'h20;
	localparam logic [7:0] ADDR_OPB0    = 8'h30;
	localparam logic [7:0] ADDR_RES0    = 8'h40;
	localparam logic [7:0] ADDR_MEM0    = 8'h50;

	// CTRL fields
	localparam int CTRL_GO_BIT   = 0;
	localparam int CTRL_PRIV_BIT = 1;
	localparam int CTRL_OP_LSB   = 8;
	localparam int CTRL_IMM_LSB  = 16;
	localparam int CTRL_ENC_LSB  = 24;

	// Feature register bit positions (leaf-1 third result)
	localparam int FEAT_STATE_SAVE_BIT = 26;
	localparam int FEAT_OSXS_BIT  = 27;
	localparam int FEAT_EXT_BIT   = 28;

	// Extended state control: bits 2:1 must both be set for vector state
	localparam logic [63:0] XCR_RESET  = 64'h0000_0000_0000_0001;
	localparam logic [63:0] XCR_VECMSK = 64'h0000_0000_0000_0006;

	// Status fields
	localparam int ST_ZF_BIT   = 0;
	localparam int ST_CF_BIT   = 1;
	localparam int ST_UD_BIT   = 2;
	localparam int ST_BUSY_BIT = 3;

	typedef enum logic [3:0] {
		OP_BCAST,
		OP_MLOAD_S,
		OP_MLOAD_D,
		OP_MSTORE_S,
		OP_MSTORE_D,
		OP_PERMV_S,
		OP_PERMV_D,
		OP_PERMI_S,
		OP_PERMI_D,
		OP_TEST_S,
		OP_TEST_D,
		OP_BLENDV,
		OP_XGET,
		OP_XSET,
		OP_MMXREF
	} smpt_op_t;

	// Encoding form: 0 legacy, 1 new 128-bit, 2 new 256-bit, 3 legacy implied mask
	typedef enum logic [1:0] {
		ENC_LEGACY,
		ENC_NEW128,
		ENC_NEW256,
		ENC_IMPLIED
	} smpt_enc_t;

	typedef struct packed {
		smpt_op_t  op;
		smpt_enc_t enc;
		logic [7:0] imm;
		logic       priv;
	} smpt_cmd_t;

	typedef struct packed {
		logic zf;
		logic cf;
		logic ud;
	} smpt_flags_t;

endpackage : smpt_pkg

// >>> smpt_sw_model.sv
// Software-side model: the instruction stream issuing APB transfers.
// Assumes one clock; the slave may hold pready low for wait states.
`timescale 1ns/1ps
module smpt_sw_model (
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o
);

	initial
	begin
		{psel_o, penable_o, pwrite_o} = 3'h0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0000_0000;
	end

	// ----------------------------------------
	// Transfer
	// ----------------------------------------
	// Entered just after a rising edge; request held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_i !== 1'b1 && n < 64);
		if (pready_i !== 1'b1)
		begin
			$display("unexpected pready exp 1 got %b", pready_i);
			tb_simd128_move_permute_test_unit.mismatches++;
			tb_simd128_move_permute_test_unit.give_verdict();
		end
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// One idle edge keeps the next setup out of this time step
		@(posedge clk_i);
	endtask : xfer
endmodule : smpt_sw_model

// >>> smpt_unit_properties.sv
// Checker: decode gating and sign-test flags seen at the unit's ports.
// Assumes operand words are written with all byte strobes set.
`timescale 1ns/1ps
module smpt_unit_properties #(
	parameter logic HW_EXT_SUPPORT = 1'b1
) (
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        zero_flag_o,
	input wire logic        carry_flag_o,
	input wire logic        undefined_opcode_fault_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Shadow of operand sign bits and vector-state enable
	// ----------------------------------------
	logic [3:0]      sa_ff, nxt_sa, sb_ff, nxt_sb;
	logic [1:0]      vb_ff, nxt_vb;
	logic            ven_ff, nxt_ven, xs_ff, nxt_xs;
	wire logic       wr  = psel_i && penable_i && pwrite_i;
	wire logic [3:0] op  = pwdata_i[11:8];
	wire logic [1:0] enc = pwdata_i[25:24];
	wire logic       go  = wr && paddr_i == smpt_pkg::ADDR_CTRL && pwdata_i[0];
	wire logic       vop = go && op <= 4'd11;
	wire logic       ud  = undefined_opcode_fault_o;
	wire logic       zs  = ~|(sa_ff & sb_ff);
	wire logic       cs  = ~|(sb_ff & ~sa_ff);
	wire logic       zd  = ~|(sa_ff & sb_ff & 4'b1010);
	wire logic       cd  = ~|(sb_ff & ~sa_ff & 4'b1010);

	always_comb
	begin
		nxt_sa = sa_ff;
		nxt_sb = sb_ff;
		nxt_vb = vb_ff;
		nxt_xs = go && op == smpt_pkg::OP_XSET;
		// A control write only counts once it was not refused
		nxt_ven = (xs_ff && !ud) ? &vb_ff : ven_ff;
		if (wr && paddr_i[7:4] == 4'h2)
			nxt_sa[paddr_i[3:2]] = pwdata_i[31];
		if (wr && paddr_i[7:4] == 4'h3)
			nxt_sb[paddr_i[3:2]] = pwdata_i[31];
		if (wr && paddr_i == smpt_pkg::ADDR_OPB0)
			nxt_vb = pwdata_i[2:1];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			{sa_ff, sb_ff, vb_ff, ven_ff, xs_ff} <= '0;
		else
			{sa_ff, sb_ff, vb_ff, ven_ff, xs_ff} <= {nxt_sa, nxt_sb, nxt_vb, nxt_ven, nxt_xs};
	end

	property p_mmx;
		go && op == smpt_pkg::OP_MMXREF && enc != smpt_pkg::ENC_LEGACY |=> ud;
	endproperty
	a_mmx: assert property (p_mmx) else $error("multimedia op accepted");
	property p_blend;
		go && op == smpt_pkg::OP_BLENDV && enc == smpt_pkg::ENC_IMPLIED |=> ud;
	endproperty
	a_blend: assert property (p_blend) else $error("implied blend accepted");
	property p_wide;
		vop && enc == smpt_pkg::ENC_NEW256 |=> ud;
	endproperty
	a_wide: assert property (p_wide) else $error("wide form accepted");
	property p_priv;
		go && op == smpt_pkg::OP_XSET && !pwdata_i[1] |=> ud;
	endproperty
	a_priv: assert property (p_priv) else $error("unprivileged write accepted");
	property p_gate;
		vop && !ven_ff |=> ud;
	endproperty
	a_gate: assert property (p_gate) else $error("vector op without state");
	property p_legal;
		vop && enc == smpt_pkg::ENC_NEW128 && ven_ff && HW_EXT_SUPPORT |=> !ud;
	endproperty
	a_legal: assert property (p_legal) else $error("legal op refused");
	property p_test_s;
		go && op == smpt_pkg::OP_TEST_S |=> ud || {zero_flag_o, carry_flag_o} == {zs, cs};
	endproperty
	a_test_s: assert property (p_test_s) else $error("single test flags");
	property p_test_d;
		go && op == smpt_pkg::OP_TEST_D |=> ud || {zero_flag_o, carry_flag_o} == {zd, cd};
	endproperty
	a_test_d: assert property (p_test_d) else $error("double test flags");

	c_test: cover property (go && op == smpt_pkg::OP_TEST_S ##1 !ud);
	c_fault: cover property (vop ##1 ud);
	c_enable: cover property (xs_ff && !ud);
endmodule : smpt_unit_properties

bind smpt_unit smpt_unit_properties #(.HW_EXT_SUPPORT(HW_EXT_SUPPORT)) u_props (
	.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.zero_flag_o, .carry_flag_o, .undefined_opcode_fault_o);

// >>> tb_simd128_move_permute_test_unit.sv
// Testbench: software model drives the unit; reads and flags checked from queues.
// Assumes read data stands with pready; flags settle after the go edge.
`timescale 1ns/1ps
module tb_simd128_move_permute_test_unit;
	logic         ref_clk_i, reset_i, psel, penable, pwrite, pready, slverr, zf, cf, ud;
	logic         go_acc = 1'b0;
	logic [7:0]   paddr, imm;
	logic [3:0]   sa, sb, sm;
	logic [31:0]  pwdata, prdata;
	logic [127:0] opa, opb, mem, res;
	logic [64:0]  word_q[$];
	logic [5:0]   flag_q[$];
	int           mismatches = 0;
	int           cmp_count = 0;

	smpt_unit dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr),
		.zero_flag_o(zf), .carry_flag_o(cf), .undefined_opcode_fault_o(ud));
	smpt_sw_model u_sw (.clk_i(ref_clk_i), .pready_i(pready), .prdata_i(prdata),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// ----------------------------------------
	// Checking and stimulus tasks
	// ----------------------------------------
	// Read data and error are taken at the edge that sees pready
	always @(posedge ref_clk_i)
	begin
		go_acc <= psel & penable & pwrite & pready & (paddr == 8'h00) & pwdata[0];
		if (psel && penable && !pwrite && pready && word_q.size() > 0)
			cmp_word(word_q.pop_front());
	end

	always @(negedge ref_clk_i)
	begin
		if (go_acc && flag_q.size() > 0)
			cmp_flags(flag_q.pop_front());
	end

	task automatic cmp_word(input logic [64:0] n);
		cmp_count++;
		if ({slverr, prdata & n[63:32]} !== {n[64], n[31:0]})
		begin
			mismatches++;
			$display("unexpected read exp %b %h got %b %h", n[64], n[31:0], slverr,
				prdata & n[63:32]);
		end
	endtask : cmp_word

	task automatic cmp_flags(input logic [5:0] n);
		cmp_count++;
		if (({ud, cf, zf} & n[5:3]) !== n[2:0])
		begin
			mismatches++;
			$display("unexpected flags exp %b got %b", n[2:0], {ud, cf, zf} & n[5:3]);
		end
	endtask : cmp_flags

	task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e,
		input logic err = 1'b0);
		word_q.push_back({err, msk, e});
		u_sw.xfer(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Note holds {mask, value} of {fault, carry, zero}
	task automatic go(input logic [3:0] op, input logic [1:0] enc, input logic [7:0] im,
		input logic priv, input logic [5:0] note);
		flag_q.push_back(note);
		u_sw.xfer(1'b1, 8'h00, {6'h00, enc, im, 4'h0, op, 6'h00, priv, 1'b1});
	endtask : go

	task automatic load();
		for (int i = 0; i < 4; i++)
		begin
			u_sw.xfer(1'b1, smpt_pkg::ADDR_OPA0 + 8'(4 * i), opa[32*i+:32]);
			u_sw.xfer(1'b1, smpt_pkg::ADDR_OPB0 + 8'(4 * i), opb[32*i+:32]);
			u_sw.xfer(1'b1, smpt_pkg::ADDR_MEM0 + 8'(4 * i), mem[32*i+:32]);
		end
	endtask : load

	function automatic logic [127:0] calc(input int op, input logic [7:0] im);
		logic [127:0] r;
		for (int i = 0; i < 4; i++)
		begin
			case (op)
				0: r[32*i+:32] = mem[31:0];
				1: r[32*i+:32] = opa[32*i+31] ? mem[32*i+:32] : 32'h0;
				2: r[32*i+:32] = opa[64*(i/2)+63] ? mem[32*i+:32] : 32'h0;
				3: r[32*i+:32] = opa[32*i+31] ? opb[32*i+:32] : mem[32*i+:32];
				4: r[32*i+:32] = opa[64*(i/2)+63] ? opb[32*i+:32] : mem[32*i+:32];
				5: r[32*i+:32] = opa[32*opb[32*i+:2]+:32];
				6: r[32*i+:32] = opa[64*opb[64*(i/2)+1]+32*(i%2)+:32];
				7: r[32*i+:32] = opa[32*im[2*i+:2]+:32];
				default: r[32*i+:32] = opa[64*im[i/2]+32*(i%2)+:32];
			endcase
		end
		return r;
	endfunction : calc

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		reset_i = 1'b1;
		void'($urandom(32'h258b5088));
		repeat (5) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(smpt_pkg::ADDR_XCR_LO, 32'hffff_ffff, 32'h0000_0001);
		rd(smpt_pkg::ADDR_FEAT, 32'h1c00_0000, 32'h1400_0000);
		rd(8'h14, 32'hffff_ffff, 32'h0000_0000, 1'b1);
		go(smpt_pkg::OP_BCAST, smpt_pkg::ENC_NEW128, 8'h00, 1'b0, 6'h24);
		u_sw.xfer(1'b1, smpt_pkg::ADDR_FEAT, 32'h0800_0000);
		rd(smpt_pkg::ADDR_FEAT, 32'h0800_0000, 32'h0800_0000);
		opa = '0;
		opb = 128'h7;
		mem = '0;
		load();
		go(smpt_pkg::OP_XSET, smpt_pkg::ENC_LEGACY, 8'h00, 1'b0, 6'h24);
		go(smpt_pkg::OP_XSET, smpt_pkg::ENC_LEGACY, 8'h00, 1'b1, 6'h20);
		go(smpt_pkg::OP_XGET, smpt_pkg::ENC_LEGACY, 8'h00, 1'b0, 6'h20);
		rd(smpt_pkg::ADDR_RES0, 32'hffff_ffff, 32'h0000_0007);
		rd(smpt_pkg::ADDR_RES0 + 8'h04, 32'hffff_ffff, 32'h0000_0000);
		for (int e = 0; e < 4; e++)
			go(smpt_pkg::OP_BCAST, 2'(e), 8'h00, 1'b0, (e == 1) ? 6'h20 : 6'h24);
		go(smpt_pkg::OP_MMXREF, smpt_pkg::ENC_NEW128, 8'h00, 1'b0, 6'h24);
		go(smpt_pkg::OP_MMXREF, smpt_pkg::ENC_LEGACY, 8'h00, 1'b0, 6'h20);
		go(smpt_pkg::OP_BLENDV, smpt_pkg::ENC_IMPLIED, 8'h00, 1'b0, 6'h24);
		go(smpt_pkg::OP_BLENDV, smpt_pkg::ENC_NEW128, 8'h00, 1'b0, 6'h20);
		repeat (6)
		begin
			opa = {$urandom, $urandom, $urandom, $urandom};
			opb = {$urandom, $urandom, $urandom, $urandom};
			mem = {$urandom, $urandom, $urandom, $urandom};
			imm = 8'($urandom);
			sa = {opa[127], opa[95], opa[63], opa[31]};
			sb = {opb[127], opb[95], opb[63], opb[31]};
			for (int op = 0; op < 11; op++)
			begin
				load();
				res = calc(op, imm);
				sm = (op == 10) ? 4'b1010 : 4'hf;
				go(4'(op), smpt_pkg::ENC_NEW128, imm, 1'b0, (op < 9) ? 6'h20 :
					{4'he, ~|(sb & ~sa & sm), ~|(sa & sb & sm)});
				for (int i = 0; i < 4 && op < 9; i++)
					rd(((op == 3 || op == 4) ? smpt_pkg::ADDR_MEM0 : smpt_pkg::ADDR_RES0)
						+ 8'(4 * i), 32'hffff_ffff, res[32*i+:32]);
			end
		end
		opa = '0;
		opb = 128'h1;
		load();
		go(smpt_pkg::OP_XSET, smpt_pkg::ENC_LEGACY, 8'h00, 1'b1, 6'h20);
		go(smpt_pkg::OP_PERMV_S, smpt_pkg::ENC_NEW128, 8'h00, 1'b0, 6'h24);
		repeat (2) @(posedge ref_clk_i);
		// A note left behind means a result never appeared
		if (word_q.size() != 0 || flag_q.size() != 0)
		begin
			mismatches++;
			$display("unexpected pending notes exp 0 got %0d", word_q.size() + flag_q.size());
		end
		give_verdict();
	end
endmodule : tb_simd128_move_permute_test_unit
